// >>> hw/loop_diag.v
// Remote loopback negotiation, test pattern generation and checking, carrier loss.
// Assumes all line and terminal bits are synchronous to aclk with a bit strobe.
// Summary of operation
// - Initiator sends preparatory pattern about two to five seconds.
// - Initiator then waits for acknowledge, forever if none arrives.
// - Acknowledge leads to acknowledged, then delay, then remote test state.
// - In test state initiator holds far unit and may send pattern.
// - Stop sends terminate; no peer answer returns to idle.
// - Peer answer to terminate makes initiator send all ones, then idle.
// - Outside test, pattern may replace user data with distinct state.
// - Responder sees preparatory pattern, reports it, sends acknowledge.
// - Responder loops line data; on terminate awaits all ones, times out.
// - Responder reports off while unit is in local loop.
// - Loop type select picks in-band V.54 loop or CSU loop.
// - Generator offers QRSS, 511-bit and 2047-bit sequences.
// - Checker flags good or bit error; alert each second during errors.
// - Error insertion corrupts pattern; error indicator blinks each second.
// - Carrier loss after 255 zeros, cleared by any pulse.
// - Timeout selectable 5 to 180 minutes or never; thirty default.
// - Clock select chooses own or terminal clock for sampling terminal data.
// - Preparatory and acknowledge sequences overwrite user data; awaiting acknowledge and the delay pass user data.
// - With V.54 disabled no loop commands are sent or answered.
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "loop_diag_defs.vh"
module loop_diag #(
  parameter CLK_HZ   = `CLK_HZ,
  parameter TICK_CYC = `CLK_HZ,
  parameter PREP_CYC = `CLK_HZ * `PREP_SECONDS
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        bit_stb,
  input  wire        user_tx_bit,
  input  wire        ext_clk_stb,
  input  wire        line_rx_bit,
  input  wire        ack_detect,
  input  wire        prep_detect,
  input  wire        term_detect,
  output reg         line_tx_bit,
  output reg         loop_code_csu,
  output reg         err_led,
  output reg         alert_pulse
);

  // ****************************************************************
  // State codes
  // ****************************************************************
  localparam S_IDLE  = 4'h0, S_PREP  = 4'h1, S_WACK  = 4'h2, S_RACK  = 4'h3;
  localparam S_DELAY = 4'h4, S_TEST  = 4'h5, S_TERM  = 4'h6, S_ONES  = 4'h7;
  localparam S_RPREP = 4'h8, S_SACK  = 4'h9, S_RLOOP = 4'ha, S_RTERM = 4'hb;
  localparam S_WONES = 4'hc;
  localparam [31:0] TERM_WAIT = 32'd2;

  // ****************************************************************
  // Register file
  // ****************************************************************
  reg  [31:0] ctrl_r;
  reg  [3:0]  tout_sel_r;
  reg  [15:0] err_cnt_r;
  reg  [3:0]  state_r;
  reg         awh_r, wh_r;
  reg  [7:0]  awa_r;
  reg  [31:0] wd_r;
  reg         start_req_r, stop_req_r;
  reg         carrier_loss_r, bit_err_r;
  reg  [7:0]  ones_run_r;
  wire        pattern_send     = ctrl_r[`CTRL_PAT_SEND];
  wire        err_insert       = ctrl_r[`CTRL_ERR_INSERT];
  wire        v54_enable       = ctrl_r[`CTRL_V54_ENABLE];
  wire        loop_type_select = ctrl_r[`CTRL_LOOP_TYPE];
  wire        tx_clock_select  = ctrl_r[`CTRL_TXCLK_SEL];
  wire        local_loop       = ctrl_r[`CTRL_LOCAL_LOOP];
  wire [1:0]  pat_sel          = ctrl_r[`CTRL_PAT_SEL_LO+1:`CTRL_PAT_SEL_LO];
  wire        do_write         = awh_r && wh_r && !s_axi_bvalid;

  function [31:0] apply_strb;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1)
        apply_strb[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      awh_r <= 1'b0; wh_r <= 1'b0; awa_r <= 8'h00; wd_r <= 32'h0;
      s_axi_awready <= 1'b0; s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0; s_axi_bresp <= 2'h0;
      ctrl_r <= `CTRL_RESET_VAL; tout_sel_r <= `TIMEOUT_DEFAULT;
      start_req_r <= 1'b0; stop_req_r <= 1'b0;
    end else begin
      start_req_r <= 1'b0;
      stop_req_r  <= 1'b0;
      s_axi_awready <= !awh_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !wh_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awh_r <= 1'b1; awa_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wh_r <= 1'b1; wd_r <= apply_strb(32'h0, s_axi_wdata, s_axi_wstrb);
      end
      if (do_write) begin
        awh_r <= 1'b0; wh_r <= 1'b0; s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        case (awa_r)
          `REG_CTRL: begin
            // Start and stop are self-clearing command bits.
            ctrl_r <= {wd_r[31:2], 2'b00};
            start_req_r <= wd_r[`CTRL_LOOP_START];
            stop_req_r  <= wd_r[`CTRL_LOOP_STOP];
          end
          `REG_TIMEOUT: tout_sel_r <= wd_r[3:0];
          `REG_STATUS, `REG_ERRCNT: ;
          default: s_axi_bresp <= 2'h2;
        endcase
      end else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0; s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0; s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (s_axi_araddr)
          `REG_CTRL:    s_axi_rdata <= ctrl_r;
          `REG_STATUS:  s_axi_rdata <= {25'h0, bit_err_r, carrier_loss_r,
                                        status_code(state_r)};
          `REG_ERRCNT:  s_axi_rdata <= {16'h0, err_cnt_r};
          `REG_TIMEOUT: s_axi_rdata <= {28'h0, tout_sel_r};
          default: begin
            s_axi_rdata <= 32'h0; s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Reported state: pattern and local loop overlay the machine
  // ****************************************************************
  function [4:0] status_code;
    input [3:0] st;
    begin
      if (local_loop && st == S_IDLE)
        status_code = 5'h10;
      else if (st == S_TEST && pattern_send)
        status_code = 5'h0e;
      else if (st == S_IDLE && pattern_send)
        status_code = 5'h0d;
      else
        status_code = {1'b0, st};
    end
  endfunction

  // ****************************************************************
  // Timebase, timeout lookup and counters
  // ****************************************************************
  reg  [31:0] tick_cnt_r;
  reg         tick_r;
  reg  [31:0] phase_cnt_r;
  reg  [13:0] loop_sec_r;
  wire [7:0]  tout_min;

  timeout_rom u_rom (
    .aclk    (aclk),
    .sel     (tout_sel_r),
    .minutes (tout_min)
  );

  wire looping  = (state_r == S_TEST) || (state_r == S_RLOOP);
  wire tout_hit = looping && tout_min != 8'h00 &&
                  loop_sec_r >= {tout_min, 6'h0} - {4'h0, tout_min, 2'h0};

  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_r <= 32'h0; tick_r <= 1'b0;
    end else begin
      tick_r <= (tick_cnt_r == TICK_CYC - 1);
      tick_cnt_r <= (tick_cnt_r == TICK_CYC - 1) ? 32'h0 : tick_cnt_r + 32'h1;
    end
  end

  // ****************************************************************
  // Loop negotiation machine
  // ****************************************************************
  reg [3:0] state_nxt;
  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE:
        if (start_req_r && v54_enable && !local_loop)
          state_nxt = S_PREP;
        else if (prep_detect && v54_enable && !local_loop)
          state_nxt = S_RPREP;
      S_PREP:  if (phase_cnt_r >= PREP_CYC - 1) state_nxt = S_WACK;
      S_WACK:  if (ack_detect) state_nxt = S_RACK;
      S_RACK:  state_nxt = S_DELAY;
      // Timed waits last at least one whole tick, so a tick just after entry cannot cut them.
      S_DELAY: if (tick_r && phase_cnt_r != 32'h0) state_nxt = S_TEST;
      S_TEST:  if (stop_req_r || tout_hit) state_nxt = S_TERM;
      S_TERM:
        if (ack_detect) state_nxt = S_ONES;
        else if (phase_cnt_r >= TERM_WAIT) state_nxt = S_IDLE;
      S_ONES:  if (tick_r && phase_cnt_r != 32'h0) state_nxt = S_IDLE;
      S_RPREP: if (!prep_detect) state_nxt = S_SACK;
      S_SACK:  if (tick_r && phase_cnt_r != 32'h0) state_nxt = S_RLOOP;
      S_RLOOP:
        if (term_detect) state_nxt = S_RTERM;
        else if (tout_hit) state_nxt = S_IDLE;
      S_RTERM: if (!term_detect) state_nxt = S_WONES;
      S_WONES:
        if (ones_run_r >= 8'hff || phase_cnt_r >= TERM_WAIT)
          state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
    if (!v54_enable && state_r != S_IDLE)
      state_nxt = S_IDLE;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= S_IDLE; phase_cnt_r <= 32'h0; loop_sec_r <= 14'h0;
    end else begin
      state_r <= state_nxt;
      // Phases in PREP count cycles; later phases count seconds.
      if (state_nxt != state_r)
        phase_cnt_r <= 32'h0;
      else if (state_r == S_PREP || tick_r)
        phase_cnt_r <= phase_cnt_r + 32'h1;
      if (!looping)
        loop_sec_r <= 14'h0;
      else if (tick_r)
        loop_sec_r <= loop_sec_r + 14'h1;
    end
  end

  // ****************************************************************
  // Pattern generator and checker
  // ****************************************************************
  function [10:0] prbs_step;
    input [10:0] s;
    input [1:0]  sel;
    begin
      case (sel)
        `PAT_511:  prbs_step = {2'b00, s[7:0], s[8] ^ s[4]};
        `PAT_2047: prbs_step = {s[9:0], s[10] ^ s[8]};
        default:   prbs_step = {s[9:0], s[10] ^ s[8] ^ s[0]};
      endcase
    end
  endfunction

  reg  [10:0] gen_r, chk_r;
  reg  [7:0]  zero_run_r;
  reg         err_pend_r, user_bit_r, sec_err_r;
  wire        pat_bit = (pat_sel == `PAT_511) ? gen_r[8] : gen_r[10];
  // Each bit is predicted from the bits already received, so the checker locks on
  // within one register length whatever the loop delay is.
  wire [10:0] chk_pred = prbs_step(chk_r, pat_sel);
  wire        chk_exp  = chk_pred[0];
  wire        pat_on  = pattern_send && (state_r == S_IDLE || state_r == S_TEST);

  always @(posedge aclk) begin
    if (!aresetn) begin
      // The three-tap QRSS feedback holds all ones forever, so the seed is a lone one.
      gen_r <= 11'h001; chk_r <= 11'h7ff; zero_run_r <= 8'h00;
      ones_run_r <= 8'h00; carrier_loss_r <= 1'b0; bit_err_r <= 1'b0;
      err_cnt_r <= 16'h0; line_tx_bit <= 1'b1; loop_code_csu <= 1'b0;
      err_led <= 1'b0; alert_pulse <= 1'b0; err_pend_r <= 1'b0;
      user_bit_r <= 1'b0; sec_err_r <= 1'b0;
    end else begin
      alert_pulse <= 1'b0;
      loop_code_csu <= loop_type_select;
      // Terminal data is latched on whichever clock the terminal launches on.
      if (tx_clock_select ? ext_clk_stb : bit_stb)
        user_bit_r <= user_tx_bit;
      if (tick_r) begin
        err_led <= err_insert ? ~err_led : 1'b0;
        alert_pulse <= sec_err_r;
        sec_err_r <= 1'b0;
      end
      // A tick seldom meets a bit strobe, so the error to be injected waits for one.
      err_pend_r <= err_insert && (bit_stb && pat_on ? 1'b0 : (err_pend_r | tick_r));
      if (bit_stb) begin
        gen_r <= prbs_step(gen_r, pat_sel);
        chk_r <= {chk_r[9:0], line_rx_bit};
        if (line_rx_bit) begin
          zero_run_r <= 8'h00;
          carrier_loss_r <= 1'b0;
          ones_run_r <= (ones_run_r == 8'hff) ? ones_run_r : ones_run_r + 8'h1;
        end else begin
          ones_run_r <= 8'h00;
          if (zero_run_r == `CARRIER_ZEROS - 1)
            carrier_loss_r <= 1'b1;
          if (zero_run_r != 8'hff)
            zero_run_r <= zero_run_r + 8'h1;
        end
        if (pat_on) begin
          bit_err_r <= line_rx_bit != chk_exp;
          if (line_rx_bit != chk_exp) begin
            sec_err_r <= 1'b1;
            err_cnt_r <= err_cnt_r + 16'h1;
          end
        end
        case (state_r)
          S_PREP, S_SACK, S_TERM: line_tx_bit <= pat_bit;
          S_ONES:  line_tx_bit <= 1'b1;
          S_RLOOP: line_tx_bit <= line_rx_bit;
          default:
            // One error bit is injected at the first bit after each one-second tick.
            line_tx_bit <= pat_on ? (pat_bit ^ (err_insert & (err_pend_r | tick_r)))
                                  : user_bit_r;
        endcase
      end
    end
  end

endmodule // loop_diag

// >>> hw/loop_diag_defs.vh
// Constants for the remote loopback and pattern test control block.
// Assumes a 250 MHz unit clock; register offsets are AXI4-Lite byte addresses.
`ifndef LOOP_DIAG_DEFS_VH
`define LOOP_DIAG_DEFS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_ERRCNT      8'h08
`define REG_TIMEOUT     8'h0c

// ****************************************************************
// Control register fields
// ****************************************************************
`define CTRL_LOOP_START   0
`define CTRL_LOOP_STOP    1
`define CTRL_PAT_SEND     2
`define CTRL_ERR_INSERT   3
`define CTRL_V54_ENABLE   4
`define CTRL_LOOP_TYPE    5
`define CTRL_TXCLK_SEL    6
`define CTRL_LOCAL_LOOP   7
`define CTRL_PAT_SEL_LO   8
`define CTRL_RESET_VAL    32'h0000_0010

// ****************************************************************
// Pattern selections
// ****************************************************************
`define PAT_QRSS        2'h0
`define PAT_511         2'h1
`define PAT_2047        2'h2

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_HZ          250000000
`define PREP_SECONDS    3
`define CARRIER_ZEROS   255
`define TIMEOUT_DEFAULT 4'h3

`endif

// >>> hw/timeout_rom.v
// Small lookup memory: loop timeout selection to minutes, registered output.
// Assumes one clock; the read datum appears one edge after the index.
`timescale 1ns/1ps
module timeout_rom (
  input  wire       aclk,
  input  wire [3:0] sel,
  output reg  [7:0] minutes
);
  always @(posedge aclk) begin
    case (sel)
      4'h0:    minutes <= 8'h05;
      4'h1:    minutes <= 8'h0a;
      4'h2:    minutes <= 8'h0f;
      4'h3:    minutes <= 8'h1e;
      4'h4:    minutes <= 8'h2d;
      4'h5:    minutes <= 8'h3c;
      4'h6:    minutes <= 8'h5a;
      4'h7:    minutes <= 8'h78;
      4'h8:    minutes <= 8'hb4;
      default: minutes <= 8'h00;
    endcase
  end
endmodule // timeout_rom

// >>> test/loop_diag_sva.sv
// Port checks for the loop diagnostic block.
// Assumes one clock and a synchronous active-low reset; bound by the bench.
`timescale 1ns/1ps
module loop_diag_sva (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        bit_stb,
  input wire        line_tx_bit,
  input wire        err_led,
  input wire        alert_pulse
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_reset_idle: assert property (disable iff (1'b0)
    !aresetn ##1 !aresetn |-> !s_axi_bvalid && !s_axi_rvalid && line_tx_bit)
    else $error("outputs not idle in reset");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid))
    else $error("read answer without request");
  chk_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  chk_tx_strobe: assert property (!$stable(line_tx_bit) |-> $past(bit_stb))
    else $error("line bit moved off strobe");
  chk_alert_once: assert property (alert_pulse |=> !alert_pulse [*8])
    else $error("alert repeated too soon");
  chk_led_blink: assert property ($changed(err_led) |=> $stable(err_led) [*8])
    else $error("error led blinks too fast");
endmodule // loop_diag_sva

// >>> test/loop_diag_tb.sv
// Self-checking bench for the loop diagnostic block with a far unit model.
// Assumes the design file and its defines header are compiled first.
`timescale 1ns/1ps
module loop_diag_tb;
  reg         aclk, aresetn;
  reg         bit_stb = 1'b0, user_tx_bit = 1'b0, ext_clk_stb = 1'b0;
  reg  [7:0]  s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata;
  reg  [3:0]  s_axi_wstrb;
  reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        line_rx_bit, ack_detect, prep_detect, term_detect;
  wire        line_tx_bit, loop_code_csu, err_led, alert_pulse;
  reg  [2:0]  pm;
  reg  [1:0]  sc = 2'h0;
  integer     n_fail, total_checks;
  integer     zc = 0;
  reg  [31:0] d;
  reg  [1:0]  r;
  loop_diag #(.TICK_CYC(20), .PREP_CYC(50)) dut (.*);
  peer_unit far (.aclk(aclk), .bit_stb(bit_stb), .line_tx_bit(line_tx_bit), .mode(pm),
    .line_rx_bit(line_rx_bit), .ack_detect(ack_detect), .prep_detect(prep_detect),
    .term_detect(term_detect));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // The bit strobe runs every fourth cycle; terminal data toggles on it.
  always @(posedge aclk) begin
    sc <= sc + 2'h1;
    bit_stb <= (sc == 2'h3);
    ext_clk_stb <= (sc == 2'h1);
    if (bit_stb) begin
      user_tx_bit <= ~user_tx_bit;
      zc <= line_rx_bit ? 0 : zc + 1;
    end
  end
  task end_sim;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    total_checks = total_checks + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task hang;
    n_fail = n_fail + 1;
    $display("CHECK FAILED handshake expected answer seen none");
    end_sim;
  endtask
  task wr(input [7:0] a, input [31:0] v);
    integer i;
    reg ad, wd;
    ad = 0;
    wd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50 && !s_axi_bvalid; i = i + 1) begin
      @(posedge aclk);
      if (s_axi_awready && !ad) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && !wd) s_axi_wvalid <= 1'b0;
      ad = ad | s_axi_awready;
      wd = wd | s_axi_wready;
    end
    if (i == 50) hang;
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
    @(posedge aclk);
  endtask
  task rd(input [7:0] a);
    integer i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50 && !s_axi_rvalid; i = i + 1) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    if (i == 50) hang;
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
  endtask
  // Polls the state code under a bound, then judges it.
  task wst(input [4:0] s, input integer lim);
    integer i;
    d = 32'hffff_ffff;
    for (i = 0; i < lim && d[4:0] !== s; i = i + 1) rd(8'h04);
    chk("state", {27'h0, s}, {27'h0, d[4:0]});
  endtask
  task t_regs;
    rd(8'h00);
    chk("ctrl reset", 32'h0000_0010, d);
    rd(8'h0c);
    chk("timeout reset", 32'h3, d);
    wr(8'h0c, 32'h8);
    rd(8'h0c);
    chk("timeout sel", 32'h8, d);
    rd(8'h10);
    chk("unmapped resp", 32'h2, {30'h0, r});
    chk("unmapped data", 32'h0, d);
    wr(8'h00, 32'h0000_0070);
    chk("csu loop", 32'h1, {31'h0, loop_code_csu});
    wr(8'h00, 32'h0000_0090);
    wst(5'h10, 3);
    wr(8'h00, 32'h0000_0000);
    wr(8'h00, 32'h0000_0001);
    repeat (100) @(posedge aclk);
    wst(5'h00, 1);
    $display("register test done");
  endtask
  task t_init;
    pm <= 3'd1;
    wr(8'h00, 32'h0000_0011);
    wst(5'h01, 2);
    repeat (20) @(posedge aclk);
    wst(5'h01, 1);
    wst(5'h02, 20);
    repeat (300) @(posedge aclk);
    wst(5'h02, 1);
    pm <= 3'd2;
    wst(5'h04, 10);
    pm <= 3'd1;
    wst(5'h05, 20);
    wr(8'h00, 32'h0000_0014);
    wst(5'h0e, 3);
    pm <= 3'd0;
    wr(8'h00, 32'h0000_0012);
    wst(5'h06, 3);
    wst(5'h00, 30);
    $display("initiator test done");
  endtask
  task t_resp;
    wr(8'h00, 32'h0000_0010);
    pm <= 3'd3;
    wst(5'h08, 5);
    pm <= 3'd1;
    wst(5'h0a, 20);
    pm <= 3'd4;
    wst(5'h0b, 5);
    pm <= 3'd0;
    wst(5'h0c, 5);
    wst(5'h00, 40);
    $display("responder test done");
  endtask
  task t_pat;
    integer k, i;
    pm <= 3'd1;
    for (k = 0; k < 3; k = k + 1) begin
      wr(8'h00, 32'h0000_0014 | (k << 8));
      wst(5'h0d, 3);
      repeat (200) @(posedge aclk);
      rd(8'h04);
      chk("pattern good", 32'h0, {31'h0, d[6]});
    end
    // Switching back to QRSS upsets the checker briefly; let that alert pass first.
    wr(8'h00, 32'h0000_0014);
    repeat (120) @(posedge aclk);
    wr(8'h00, 32'h0000_001c);
    for (i = 0; i < 200 && !alert_pulse; i = i + 1) @(posedge aclk);
    chk("alert", 32'h1, {31'h0, alert_pulse});
    d[0] = err_led;
    repeat (25) @(posedge aclk);
    chk("led blink", {31'h0, ~d[0]}, {31'h0, err_led});
    wr(8'h00, 32'h0000_0010);
    $display("pattern test done");
  endtask
  task t_carrier;
    integer i;
    reg early;
    pm <= 3'd1;
    wst(5'h00, 1);
    repeat (20) @(posedge aclk);
    pm <= 3'd0;
    early = 0;
    d = 0;
    for (i = 0; i < 400 && !d[5]; i = i + 1) begin
      rd(8'h04);
      if (d[5] && zc < 255) early = 1;
    end
    chk("carrier early", 32'h0, {31'h0, early});
    chk("carrier loss", 32'h1, {31'h0, d[5]});
    pm <= 3'd1;
    repeat (12) @(posedge aclk);
    rd(8'h04);
    chk("carrier back", 32'h0, {31'h0, d[5]});
    $display("carrier test done");
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    pm = 3'd0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    aresetn = 1'b0;
    n_fail = 0;
    total_checks = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_init;
    t_resp;
    t_pat;
    t_carrier;
    end_sim;
  end
  initial begin
    #390000;
    hang;
  end
endmodule // loop_diag_tb
bind loop_diag loop_diag_sva chk (.*);

// >>> test/peer_unit.sv
// Far line unit model: silent line, loopback, or line code detector levels.
// Assumes the bench picks the mode; bits move on the shared bit strobe.
`timescale 1ns/1ps
module peer_unit (
  input  wire       aclk,
  input  wire       bit_stb,
  input  wire       line_tx_bit,
  input  wire [2:0] mode,
  output reg        line_rx_bit,
  output wire       ack_detect,
  output wire       prep_detect,
  output wire       term_detect
);
  // Mode 0 is a dead line: no pulses at all, which is what carrier loss needs.
  always @(posedge aclk) begin
    if (bit_stb) begin
      line_rx_bit <= (mode == 3'd0) ? 1'b0 : line_tx_bit;
    end
  end
  assign ack_detect  = (mode == 3'd2);
  assign prep_detect = (mode == 3'd3);
  assign term_detect = (mode == 3'd4);
endmodule // peer_unit
